/* File: bench/lpvi_host.sv */
// host model writing command and data bytes
`default_nettype none
module lpvi_host (
  input  wire logic       core_clk,        // clock
  output logic            wr_strobe,       // write pulse
  output logic            cmd_data_select, // low: command
  output logic      [7:0] wr_data          // byte
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_strobe = 1'b0;
    cmd_data_select = 1'b1;
    wr_data = 8'h00;
  end
  // released lines invert so a stale byte never looks valid
  task automatic put(input logic a0, input logic [7:0] d);
    @(posedge core_clk);
    wr_strobe <= 1'b1;
    cmd_data_select <= a0;
    wr_data <= d;
    @(posedge core_clk);
    wr_strobe <= 1'b0;
    cmd_data_select <= ~a0;
    wr_data <= ~d;
  endtask
  task automatic vol(input logic [5:0] lvl);
    put(1'b0, 8'h81);
    put(1'b0, {2'b00, lvl});
  endtask
endmodule
`default_nettype wire

/* File: bench/lpvi_props.sv */
// port-level assertions for the power, volume and indicator decoder
`default_nettype none
module lpvi_props (
  input wire logic       core_clk,                 // clock
  input wire logic       srst,                     // reset
  input wire logic       wr_strobe,                // write
  input wire logic       cmd_data_select,          // low: cmd
  input wire logic [7:0] wr_data,                  // byte
  input wire logic [2:0] regulator_resistor_ratio, // ratio
  input wire logic [5:0] volume_level,             // level
  input wire logic       indicator_on,             // ind on
  input wire logic       display_on,               // disp
  input wire logic       all_points_on,            // all on
  input wire logic       power_save,               // save
  input wire logic       sleep_mode,               // sleep
  input wire logic       standby_mode,             // standby
  input wire logic       osc_enable,               // osc
  input wire logic       supply_enable,            // supply
  input wire logic       driver_enable,            // drivers
  input wire logic       blanking_ctrl_out         // blank
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  wire logic cmd = wr_strobe && !cmd_data_select;
  // ==========================================
  // checks
  chk_blank_save: assert property (
    blanking_ctrl_out == !power_save) else $error("blanking out of step");
  chk_save_enter: assert property (
    $rose(all_points_on) && !display_on |-> ##[0:1] power_save) else $error("no save");
  chk_save_pick: assert property (
    $rose(power_save) |-> sleep_mode == !indicator_on && standby_mode == indicator_on)
    else $error("wrong save kind");
  chk_sleep_off: assert property (
    sleep_mode |-> !osc_enable && !supply_enable && !driver_enable)
    else $error("sleep left a circuit running");
  chk_standby_run: assert property (
    standby_mode |-> osc_enable && !supply_enable && !driver_enable && !sleep_mode)
    else $error("standby circuit state wrong");
  chk_vol_pair: assert property (
    (cmd && wr_data == 8'h81) ##2 cmd |-> ##3 volume_level == $past(wr_data[5:0], 3))
    else $error("level not loaded");
  chk_ratio_set: assert property (
    !$past(cmd && wr_data == 8'h81, 2) && cmd && wr_data[7:3] == 5'b00100
    |-> ##3 regulator_resistor_ratio == $past(wr_data[2:0], 3)) else $error("ratio");
  chk_standby_sleep: assert property (
    standby_mode && cmd && wr_data == 8'hE2 |-> ##3 sleep_mode) else $error("no sleep");
endmodule
bind lpvi_cmd lpvi_props chk (.*);
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for the power, volume and indicator decoder
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] r;
    logic [5:0] v;
    logic [1:0] b;
    logic       on;
    logic [1:0] m;
    logic       ps, sl, sb, bl, os;
  } lpvi_obs_t;
  logic       core_clk, srst, wr_strobe, cmd_data_select, indicator_on;
  logic       indicator_segment_out, display_on, all_points_on, power_save;
  logic       sleep_mode, standby_mode, osc_enable, blanking_ctrl_out, cmd_ignored;
  logic       supply_enable, driver_enable;
  logic [7:0] wr_data;
  logic [2:0] regulator_resistor_ratio;
  logic [5:0] volume_level;
  logic [1:0] boost_ratio, indicator_mode, m;
  lpvi_obs_t  seen, last_s, exp_s, last_note;
  lpvi_obs_t  notes[$];
  int         err_count, samples_checked, drops;
  int         tg[4];
  integer     seed;
  lpvi_cmd #(.SLOW_CYC(4), .FAST_CYC(2)) uut (.*);
  lpvi_host host (.core_clk(core_clk), .wr_strobe(wr_strobe),
    .cmd_data_select(cmd_data_select), .wr_data(wr_data));
  assign seen = {regulator_resistor_ratio, volume_level, boost_ratio, indicator_on,
    indicator_mode, power_save, sleep_mode, standby_mode, blanking_ctrl_out, osc_enable};
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ==========================================
  // helpers
  task automatic check(input logic [18:0] got, input logic [18:0] want);
    samples_checked++;
    if (got !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic note();
    if (exp_s !== last_note) begin
      notes.push_back(exp_s);
      last_note = exp_s;
    end
  endtask
  task automatic cmd(input logic [7:0] d);
    host.put(1'b0, d);
  endtask
  task automatic toggles(output int n);
    logic p;
    n = 0;
    p = indicator_segment_out;
    repeat (24) begin
      @(posedge core_clk);
      if (indicator_segment_out !== p) n++;
      p = indicator_segment_out;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // any change in seen with no note pending is a stray change
  always @(posedge core_clk) begin
    if (!srst && seen !== last_s) begin
      if (notes.size() == 0) check(seen, last_s);
      else check(seen, notes.pop_front());
    end
    if (!srst && cmd_ignored === 1'b1) drops++;
    last_s = seen;
  end
  // ==========================================
  // scenarios
  initial begin
    seed = 32'hEE5ABCFD;
    srst = 1'b1;
    exp_s = {3'h0, 6'h20, 2'h0, 1'b0, 2'h0, 5'b00011};
    last_note = exp_s;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    check(seen, exp_s);
    for (int i = 0; i < 9; i++) begin
      exp_s.r = (i < 8) ? 3'(i) : 3'($random(seed));
      cmd({5'b00100, exp_s.r});
      note();
    end
    exp_s.v = 6'($random(seed));
    host.vol(exp_s.v);
    note();
    host.vol(6'h3F);
    exp_s.v = 6'h3F;
    note();
    host.vol(6'h20);
    exp_s.v = 6'h20;
    note();
    cmd(8'h25);
    exp_s.r = 3'h5;
    note();
    for (int i = 0; i < 4; i++) begin
      m = 2'(i + 1);
      cmd(8'hAD);
      exp_s.on = 1'b1;
      note();
      if (i == 0) begin
        cmd(8'hA5);
        host.put(1'b1, 8'($random(seed)));
      end
      cmd({6'h00, m});
      exp_s.m = m;
      note();
      repeat (4) @(posedge core_clk);
      toggles(tg[m]);
    end
    check(19'(tg[2] > tg[1] && tg[1] > 0 && tg[3] == 0 && tg[0] == 0), 19'h1);
    cmd(8'hAF);
    repeat (3) @(posedge core_clk);
    check(19'(display_on), 19'h1);
    cmd(8'hAE);
    cmd(8'hAC);
    exp_s.on = 1'b0;
    note();
    cmd(8'h2F);
    cmd(8'hF8);
    cmd(8'hA5);
    cmd(8'h03);
    exp_s.b = 2'h3;
    note();
    check(19'({supply_enable, driver_enable, display_on, all_points_on}), 19'hC);
    cmd(8'hA5);
    {exp_s.ps, exp_s.sl, exp_s.bl, exp_s.os} = 4'b1100;
    note();
    repeat (3) @(posedge core_clk);
    check(19'({all_points_on, supply_enable, driver_enable}), 19'h4);
    cmd(8'hA4);
    {exp_s.ps, exp_s.sl, exp_s.bl, exp_s.os} = 4'b0011;
    note();
    cmd(8'hAD);
    exp_s.on = 1'b1;
    note();
    cmd(8'h03);
    exp_s.m = 2'h3;
    note();
    cmd(8'hA5);
    {exp_s.ps, exp_s.sb, exp_s.bl} = 3'b110;
    note();
    repeat (4) @(posedge core_clk);
    check(19'(indicator_segment_out), 19'h1);
    cmd(8'hE2);
    exp_s = {3'h0, 6'h20, exp_s.b, 3'b000, 5'b11000};
    note();
    cmd(8'hA4);
    {exp_s.ps, exp_s.sl, exp_s.bl, exp_s.os} = 4'b0011;
    note();
    repeat (8) @(posedge core_clk);
    check(19'(drops), 19'h3);
    check(19'(notes.size()), 19'h0);
    check(19'({supply_enable, driver_enable, all_points_on}), 19'h6);
    give_verdict();
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: hdl/lpvi_blink.sv */
// indicator blink timer on the internal oscillator
`include "lpvi_defs.svh"
`default_nettype none
module lpvi_blink #(
  parameter int unsigned SLOW_CYC = `LPVI_BLINK_SLOW_MS * 1000 * `LPVI_CLK_MHZ / 2,
  parameter int unsigned FAST_CYC = `LPVI_BLINK_FAST_MS * 1000 * `LPVI_CLK_MHZ / 2
) (
  input wire logic core_clk, // clock
  input wire logic srst,     // sync reset
  lpvi_blink_if.timer bl     // mode in, lit out
);
  if (SLOW_CYC < 1 || FAST_CYC < 1) begin : g_bad_half
    $error("blink half periods must be at least one cycle");
  end

  typedef struct packed {
    logic [31:0] cnt;
    logic        phase;
  } lpvi_blink_st_t;

  lpvi_blink_st_t st;
  lpvi_blink_st_t next_st;
  logic [31:0]    half;

  // ======================================
  // half period per mode (ms figures halved: toggle twice per interval)
  always_comb begin
    half = (bl.mode == 2'h1) ? SLOW_CYC[31:0] : FAST_CYC[31:0];
    next_st = st;
    if (!bl.run || bl.mode == 2'h0 || bl.mode == 2'h3) begin
      next_st.cnt = 32'h0;
      next_st.phase = 1'b1;
    end else if (st.cnt >= half - 32'h1) begin
      next_st.cnt = 32'h0;
      next_st.phase = ~st.phase;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) st <= '0;
    else st <= next_st;
  end

  assign bl.lit = bl.run && (bl.mode == 2'h3 || (bl.mode != 2'h0 && st.phase));
endmodule
`default_nettype wire

/* File: hdl/lpvi_blink_if.sv */
// carrier between decoder and blink timer
`default_nettype none
interface lpvi_blink_if;
  logic       run;
  logic [1:0] mode;
  logic       lit;
  modport ctrl  (output run, output mode, input lit);
  modport timer (input run, input mode, output lit);
endinterface
`default_nettype wire

/* File: hdl/lpvi_cmd.sv */
// command decoder: resistor ratio, volume, indicator, power save
// What this block does
// - 0x20..0x27 loads three-bit resistor ratio
// - after 0x81 only level byte accepted
// - level byte loads six bits, 64 levels
// - level loaded releases volume mode
// - 0xAC indicator off, 0xAD on and arm
// - after 0xAD only indicator register accepted
// - two bits select off, slow, fast, steady
// - indicator changed only by indicator commands and reset command 0xE2
// - all-on while display off enters power save
// - indicator off sleep, indicator on standby
// - settings and memory access kept in save
// - sleep stops oscillator, supply, all drivers
// - standby stops supply, keeps indicator running
// - reset command in standby goes to sleep
// - blanking output low in power save
// - booster mode accepts only ratio byte
`include "lpvi_defs.svh"
`default_nettype none
module lpvi_cmd #(
  parameter int unsigned SLOW_CYC = `LPVI_BLINK_SLOW_MS * 1000 * `LPVI_CLK_MHZ / 2,
  parameter int unsigned FAST_CYC = `LPVI_BLINK_FAST_MS * 1000 * `LPVI_CLK_MHZ / 2
) (
  input  wire logic       core_clk,              // 100 MHz clock
  input  wire logic       srst,                  // sync reset, high
  input  wire logic       wr_strobe,             // one-cycle byte write
  input  wire logic       cmd_data_select,       // low: command byte
  input  wire logic [7:0] wr_data,               // byte from host
  output logic      [2:0] regulator_resistor_ratio, // ratio, 0 smallest
  output logic      [5:0] volume_level,          // drive level register
  output logic      [1:0] boost_ratio,           // step-up ratio register
  output logic            indicator_on,          // indicator enabled
  output logic      [1:0] indicator_mode,        // indicator register
  output logic            indicator_segment_out, // static indicator drive
  output logic            display_on,            // display on flag
  output logic            all_points_on,         // all-on flag
  output logic            power_save,            // in sleep or standby
  output logic            sleep_mode,            // in sleep
  output logic            standby_mode,          // in standby
  output logic            osc_enable,            // oscillator run
  output logic            supply_enable,         // panel supply run
  output logic            driver_enable,         // multiplexed drivers run
  output logic            blanking_ctrl_out,     // low in power save
  output logic            cmd_ignored            // pulse: byte rejected
);
  // a zero half period would leave the blink phase frozen
  if (SLOW_CYC < 1 || FAST_CYC < 1) begin : g_bad_half
    $error("blink half periods must be at least one cycle");
  end

  typedef struct packed {
    lpvi_pkg::lpvi_arm_t arm;
    lpvi_pkg::lpvi_pwr_t pwr;
    logic [2:0]          ratio;
    logic [5:0]          vol;
    logic [1:0]          boost;
    logic [2:0]          pctl;
    logic                ind_on;
    logic [1:0]          ind_mode;
    logic                disp_on;
    logic                all_on;
    logic                seg;
    logic                ign;
    logic                was_cmd;
    logic                was_data;
    logic [7:0]          data;
  } lpvi_cmd_st_t;

  lpvi_cmd_st_t st;
  lpvi_cmd_st_t next_st;
  lpvi_blink_if bl ();

  lpvi_blink #(
    .SLOW_CYC (SLOW_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_blink (
    .core_clk (core_clk),
    .srst     (srst),
    .bl       (bl)
  );

  // sleep halts the oscillator, so the indicator stops with it
  assign bl.run  = st.ind_on && st.pwr != lpvi_pkg::LPVI_PWR_SLEEP;
  assign bl.mode = st.ind_mode;

  // ======================================
  // decode: input registered once, acted upon next cycle
  always_comb begin
    next_st = st;
    next_st.was_cmd = wr_strobe && !cmd_data_select;
    next_st.was_data = wr_strobe && cmd_data_select;
    next_st.data = wr_data;
    next_st.ign = 1'b0;
    next_st.seg = bl.lit;
    if (st.was_cmd) begin
      case (st.arm)
        lpvi_pkg::LPVI_ARM_VOLUME: begin
          next_st.vol = st.data[5:0];
          next_st.arm = lpvi_pkg::LPVI_ARM_NONE;
        end
        lpvi_pkg::LPVI_ARM_INDICATOR: begin
          if (st.data[7:2] == 6'h00) begin
            next_st.ind_mode = st.data[1:0];
            next_st.arm = lpvi_pkg::LPVI_ARM_NONE;
          end else begin
            next_st.ign = 1'b1;
          end
        end
        lpvi_pkg::LPVI_ARM_BOOST: begin
          if (st.data[7:2] == 6'h00 && st.data[1:0] != 2'h2) begin
            next_st.boost = st.data[1:0];
            next_st.arm = lpvi_pkg::LPVI_ARM_NONE;
          end else begin
            next_st.ign = 1'b1;
          end
        end
        default: begin
          if (st.data[7:3] == 5'(`LPVI_CMD_RATIO_BASE >> 3)) begin
            next_st.ratio = st.data[2:0];
          end else if (st.data[7:3] == `LPVI_CMD_POWER) begin
            next_st.pctl = st.data[2:0];
          end else begin
            case (st.data)
              `LPVI_CMD_VOL_MODE:   next_st.arm = lpvi_pkg::LPVI_ARM_VOLUME;
              `LPVI_CMD_BOOST_MODE: next_st.arm = lpvi_pkg::LPVI_ARM_BOOST;
              `LPVI_CMD_IND_OFF:    next_st.ind_on = 1'b0;
              `LPVI_CMD_IND_ON: begin
                next_st.ind_on = 1'b1;
                next_st.arm = lpvi_pkg::LPVI_ARM_INDICATOR;
              end
              `LPVI_CMD_DISP_OFF:   next_st.disp_on = 1'b0;
              `LPVI_CMD_DISP_ON:    next_st.disp_on = 1'b1;
              `LPVI_CMD_ALL_OFF: begin
                next_st.all_on = 1'b0;
                next_st.pwr = lpvi_pkg::LPVI_PWR_RUN;
              end
              `LPVI_CMD_ALL_ON: begin
                next_st.all_on = 1'b1;
                if (!st.disp_on && st.pwr == lpvi_pkg::LPVI_PWR_RUN) begin
                  next_st.pwr = st.ind_on ? lpvi_pkg::LPVI_PWR_STANDBY
                                          : lpvi_pkg::LPVI_PWR_SLEEP;
                end
              end
              `LPVI_CMD_RESET: begin
                next_st.ratio = `LPVI_RST_RATIO;
                next_st.vol = `LPVI_RST_VOLUME;
                next_st.ind_on = 1'b0;
                next_st.ind_mode = `LPVI_RST_INDREG;
                if (st.pwr == lpvi_pkg::LPVI_PWR_STANDBY) begin
                  next_st.pwr = lpvi_pkg::LPVI_PWR_SLEEP;
                end
              end
              default: next_st.ign = 1'b0;
            endcase
          end
        end
      endcase
    end else if (st.was_data && st.arm != lpvi_pkg::LPVI_ARM_NONE) begin
      // memory writes still served, but a pending pair drops them
      next_st.ign = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
      st.vol <= `LPVI_RST_VOLUME;
    end else begin
      st <= next_st;
    end
  end

  // ======================================
  // outputs, all from the state register
  logic in_save;
  assign in_save = st.pwr != lpvi_pkg::LPVI_PWR_RUN;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      regulator_resistor_ratio <= `LPVI_RST_RATIO;
      volume_level <= `LPVI_RST_VOLUME;
      boost_ratio <= `LPVI_RST_BOOST;
      indicator_on <= 1'b0;
      indicator_mode <= `LPVI_RST_INDREG;
      indicator_segment_out <= 1'b0;
      display_on <= 1'b0;
      all_points_on <= 1'b0;
      power_save <= 1'b0;
      sleep_mode <= 1'b0;
      standby_mode <= 1'b0;
      osc_enable <= 1'b1;
      supply_enable <= 1'b0;
      driver_enable <= 1'b0;
      blanking_ctrl_out <= 1'b1;
      cmd_ignored <= 1'b0;
    end else begin
      regulator_resistor_ratio <= st.ratio;
      volume_level <= st.vol;
      boost_ratio <= st.boost;
      indicator_on <= st.ind_on;
      indicator_mode <= st.ind_mode;
      indicator_segment_out <= st.seg;
      display_on <= st.disp_on;
      all_points_on <= st.all_on;
      power_save <= in_save;
      sleep_mode <= st.pwr == lpvi_pkg::LPVI_PWR_SLEEP;
      standby_mode <= st.pwr == lpvi_pkg::LPVI_PWR_STANDBY;
      osc_enable <= st.pwr != lpvi_pkg::LPVI_PWR_SLEEP;
      supply_enable <= !in_save && st.pctl != 3'h0;
      driver_enable <= !in_save;
      blanking_ctrl_out <= !in_save;
      cmd_ignored <= st.ign;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/lpvi_defs.svh */
// constants for the power, volume and indicator command decoder
`ifndef LPVI_DEFS_SVH
`define LPVI_DEFS_SVH
`define LPVI_CMD_RATIO_BASE   8'h20
`define LPVI_CMD_VOL_MODE     8'h81
`define LPVI_CMD_IND_OFF      8'hAC
`define LPVI_CMD_IND_ON       8'hAD
`define LPVI_CMD_BOOST_MODE   8'hF8
`define LPVI_CMD_DISP_OFF     8'hAE
`define LPVI_CMD_DISP_ON      8'hAF
`define LPVI_CMD_ALL_OFF      8'hA4
`define LPVI_CMD_ALL_ON       8'hA5
`define LPVI_CMD_RESET        8'hE2
`define LPVI_CMD_POWER        5'b00101
`define LPVI_RST_RATIO        3'h0
`define LPVI_RST_VOLUME       6'h20
`define LPVI_RST_INDREG       2'h0
`define LPVI_RST_BOOST        2'h0
`define LPVI_RST_POWER        3'h0
`define LPVI_BLINK_SLOW_MS    1000
`define LPVI_BLINK_FAST_MS    500
`define LPVI_CLK_MHZ          100
`endif

/* File: hdl/lpvi_pkg.sv */
// types for the command decoder's arm and power states
`default_nettype none
package lpvi_pkg;
  typedef enum logic [1:0] {
    LPVI_ARM_NONE,
    LPVI_ARM_VOLUME,
    LPVI_ARM_INDICATOR,
    LPVI_ARM_BOOST
  } lpvi_arm_t;

  typedef enum logic [1:0] {
    LPVI_PWR_RUN,
    LPVI_PWR_SLEEP,
    LPVI_PWR_STANDBY
  } lpvi_pwr_t;
endpackage
`default_nettype wire
